/* core/octet_host_bus_port.sv */
`timescale 1ns/100ps
// What this block does
// - seven-bit address selects the one register each access targets
// - eight-bit data; device drives only during reads, host during writes
// - multiplexed: address latched on falling edge of address latch strobe
// - chip select low opens access; read and write strobes ignored while it is high
// - static mode pin: low split strobes, high data strobe plus direction
// - split style: selected read strobe enables drivers with addressed data
// - split style: selected write strobe loads addressed register from bus
// - data-strobe style: the data strobe times each transfer
// - data-strobe style: direction input tells read from write
// - one interrupt output serves every source of every channel
// - each source maskable; masked sources never raise the output
// - channel summary and per-source status registers show pending causes
// - pin config selects push-pull high, push-pull low or open-drain low
// - every register directly addressed, no paging
module octet_host_bus_port
    import octet_port_pkg::*;
#(
    parameter int NCH = CHANNELS,
    parameter int NSRC = SRC_W
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire hostPins_t           hostPins,
    input  wire logic [NCH*NSRC-1:0] irqEvent,
    output logic      [DATA_W-1:0]   dataOut,
    output logic                     dataOe,
    output logic                     irqOut,
    output logic                     irqOe
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0]   regFile [0:(1<<ADDR_W)-1];
    logic                prevAle,     next_prevAle;
    logic                aleSeen,     next_aleSeen;
    logic [ADDR_W-1:0]   latchedAddr, next_latchedAddr;
    logic                prevRd,      next_prevRd;
    logic                prevWr,      next_prevWr;
    logic [ADDR_W-1:0]   accAddr,     next_accAddr;
    logic [DATA_W-1:0]   wrData,      next_wrData;
    logic [NCH*NSRC-1:0] isr,         next_isr;
    logic [NCH*NSRC-1:0] imr,         next_imr;
    logic [1:0]          pinCfg,      next_pinCfg;
    logic [DATA_W-1:0]   next_dataOut;
    logic                next_dataOe;
    logic                next_irqOut;
    logic                next_irqOe;

    logic [ADDR_W-1:0]   effAddr;
    logic                rdActive;
    logic                wrActive;
    logic                wrCommit;
    logic                rdDone;
    logic [DATA_W-1:0]   rdByte;
    logic [NCH-1:0]      summary;
    logic                pending;

    // ------------------------------------------------------------
    // strobe decode
    // ------------------------------------------------------------
    always_comb begin
        // once a latch edge is seen the bus is taken as multiplexed
        effAddr = aleSeen ? latchedAddr : hostPins.addr;
        if (hostPins.busMode) begin
            rdActive = !hostPins.csN && !hostPins.strobeA
                       && hostPins.strobeB;
            wrActive = !hostPins.csN && !hostPins.strobeA
                       && !hostPins.strobeB;
        end else begin
            rdActive = !hostPins.csN && !hostPins.strobeA;
            wrActive = !hostPins.csN && !hostPins.strobeB;
        end
        // commit at strobe end so data has settled; strobes overlap never
        wrCommit = prevWr && !wrActive;
        rdDone   = prevRd && !rdActive;
    end

    // ------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            summary[c] = |(isr[c*NSRC +: NSRC] & ~imr[c*NSRC +: NSRC]);
        end
        pending = |summary;
    end

    // ------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------
    always_comb begin
        int ch;
        ch = int'(effAddr[5:4]);
        rdByte = regFile[effAddr];
        // only +0..+3 of each block hold status and masks
        if (effAddr < IRQ_BLOCK_END && ch < NCH
            && effAddr[3:2] == 2'h0) begin
            case (effAddr[1:0])
                OFS_SRC0:  rdByte = isr[ch*NSRC +: 8];
                OFS_SRC1:  rdByte = isr[ch*NSRC+8 +: 8];
                OFS_MASK0: rdByte = imr[ch*NSRC +: 8];
                default:   rdByte = imr[ch*NSRC+8 +: 8];
            endcase
        end else if (effAddr == ADDR_SUMMARY) begin
            rdByte = {{(DATA_W-NCH){1'b0}}, summary};
        end else if (effAddr == ADDR_PIN_CFG) begin
            rdByte = {6'h00, pinCfg};
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        int ch;
        ch               = int'(accAddr[5:4]);
        next_prevAle     = hostPins.ale;
        next_aleSeen     = aleSeen;
        next_latchedAddr = latchedAddr;
        if (prevAle && !hostPins.ale) begin
            next_latchedAddr = hostPins.addr;
            next_aleSeen     = 1'b1;
        end
        next_prevRd  = rdActive;
        next_prevWr  = wrActive;
        next_accAddr = (rdActive || wrActive) ? effAddr : accAddr;
        next_wrData  = wrActive ? hostPins.data : wrData;
        next_isr     = isr;
        next_imr     = imr;
        next_pinCfg  = pinCfg;
        // status cleared by reading it
        if (rdDone && accAddr < IRQ_BLOCK_END && ch < NCH
            && accAddr[3:2] == 2'h0) begin
            if (accAddr[1:0] == OFS_SRC0) begin
                next_isr[ch*NSRC +: 8] = 8'h00;
            end else if (accAddr[1:0] == OFS_SRC1) begin
                next_isr[ch*NSRC+8 +: 8] = 8'h00;
            end
        end
        if (wrCommit && accAddr < IRQ_BLOCK_END && ch < NCH
            && accAddr[3:2] == 2'h0) begin
            if (accAddr[1:0] == OFS_MASK0) begin
                next_imr[ch*NSRC +: 8] = wrData;
            end else if (accAddr[1:0] == OFS_MASK1) begin
                next_imr[ch*NSRC+8 +: 8] = wrData;
            end
        end else if (wrCommit && accAddr == ADDR_PIN_CFG) begin
            next_pinCfg = wrData[1:0];
        end
        // a new event beats a clear in the same cycle
        next_isr = next_isr | irqEvent;
        next_dataOe  = rdActive;
        next_dataOut = rdActive ? rdByte : dataOut;
        case (pinCfg)
            IRQ_PP_HIGH: begin
                next_irqOut = pending;
                next_irqOe  = 1'b1;
            end
            IRQ_PP_LOW: begin
                next_irqOut = !pending;
                next_irqOe  = 1'b1;
            end
            default: begin
                next_irqOut = 1'b0;
                next_irqOe  = pending;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prevAle     <= 1'b0;
            aleSeen     <= 1'b0;
            latchedAddr <= '0;
            prevRd      <= 1'b0;
            prevWr      <= 1'b0;
            accAddr     <= '0;
            wrData      <= '0;
            isr         <= '0;
            imr         <= {(NCH*NSRC/8){MASK_RESET}};
            pinCfg      <= IRQ_OD_LOW;
            dataOut     <= '0;
            dataOe      <= 1'b0;
            irqOut      <= 1'b0;
            irqOe       <= 1'b0;
        end else begin
            prevAle     <= next_prevAle;
            aleSeen     <= next_aleSeen;
            latchedAddr <= next_latchedAddr;
            prevRd      <= next_prevRd;
            prevWr      <= next_prevWr;
            accAddr     <= next_accAddr;
            wrData      <= next_wrData;
            isr         <= next_isr;
            imr         <= next_imr;
            pinCfg      <= next_pinCfg;
            dataOut     <= next_dataOut;
            dataOe      <= next_dataOe;
            irqOut      <= next_irqOut;
            irqOe       <= next_irqOe;
        end
    end

    // plain storage keeps no reset: software initialises it
    always_ff @(posedge clk) begin
        if (wrCommit) begin
            regFile[accAddr] <= wrData;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ale_latch_a: assert property (prevAle && !hostPins.ale
        |=> latchedAddr == $past(hostPins.addr))
        else $error("address not latched on strobe fall");
    rd_data_a: assert property (rdActive
        |=> dataOe && dataOut == $past(rdByte))
        else $error("read data not presented");
    cs_idle_a: assert property (hostPins.csN |=> !dataOe)
        else $error("bus driven without chip select");
    split_rd_a: assert property (!hostPins.busMode
        && !hostPins.csN && !hostPins.strobeA |=> dataOe)
        else $error("split read did not drive bus");
    dir_write_a: assert property (hostPins.busMode
        && !hostPins.strobeB |=> !dataOe)
        else $error("bus driven during strobed write");
    cfg_write_a: assert property (wrCommit
        && accAddr == ADDR_PIN_CFG |=> pinCfg == $past(wrData[1:0]))
        else $error("pin config write lost");
    src_sticky_a: assert property (irqEvent != '0
        |=> (isr & $past(irqEvent)) == $past(irqEvent))
        else $error("interrupt event lost");
    pp_high_a: assert property (pinCfg == IRQ_PP_HIGH
        && $stable(pinCfg) ##0 pending |=> irqOut && irqOe)
        else $error("active high request missing");
    od_release_a: assert property (pinCfg == IRQ_OD_LOW
        && !pending |=> !irqOe && !irqOut)
        else $error("open drain request not released");
    mask_gate_a: assert property ((isr & ~imr) == '0
        && pinCfg == IRQ_PP_HIGH |=> !irqOut)
        else $error("masked source raised request");

    read_c:  cover property (rdActive ##1 !rdActive);
    write_c: cover property (wrActive ##1 wrCommit);
    ale_c:   cover property (prevAle ##1 !prevAle && aleSeen);
    irq_c:   cover property (pending ##1 !pending);

endmodule // octet_host_bus_port

/* core/octet_port_pkg.sv */
package octet_port_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W   = 7;
    localparam int DATA_W   = 8;
    localparam int CHANNELS = 4;
    localparam int SRC_W    = 16;  // two status bytes per channel

    // ------------------------------------------------------------
    // interrupt register placement
    // ------------------------------------------------------------
    localparam logic [6:0] IRQ_BLOCK_END = 7'h40; // ch*16 + 0..3 below
    localparam logic [1:0] OFS_SRC0      = 2'h0;
    localparam logic [1:0] OFS_SRC1      = 2'h1;
    localparam logic [1:0] OFS_MASK0     = 2'h2;
    localparam logic [1:0] OFS_MASK1     = 2'h3;
    localparam logic [6:0] ADDR_SUMMARY  = 7'h40;
    localparam logic [6:0] ADDR_PIN_CFG  = 7'h41;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_RESET    = 8'hFF;
    localparam logic [7:0] REG_RESET     = 8'h00;

    // ------------------------------------------------------------
    // interrupt pin styles
    // ------------------------------------------------------------
    localparam logic [1:0] IRQ_OD_LOW  = 2'h0;
    localparam logic [1:0] IRQ_PP_LOW  = 2'h1;
    localparam logic [1:0] IRQ_PP_HIGH = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              ale;
        logic              csN;
        logic              strobeA;  // read strobe, or data strobe
        logic              strobeB;  // write strobe, or direction
        logic              busMode;  // 0 split strobes, 1 data strobe
    } hostPins_t;

endpackage

/* tb/host_cpu_model.sv */
`timescale 1ns/100ps
module host_cpu_model
    import octet_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] dataOut,
    input  wire logic              dataOe,
    output hostPins_t              pins
);
    logic              busMode  = 1'b0;
    logic              muxed    = 1'b0;
    logic              hostOe   = 1'b0;
    logic [DATA_W-1:0] hostData = 8'h00;
    logic [ADDR_W-1:0] addrPins = 7'h00;
    logic              ale      = 1'b0;
    logic              csN      = 1'b1;
    logic              sA       = 1'b1;
    logic              sB       = 1'b1;
    logic [DATA_W-1:0] bus;

    // released data lines float up to the pull-ups
    assign bus = dataOe ? dataOut : (hostOe ? hostData : 8'hFF);
    assign pins = '{addr: muxed ? bus[ADDR_W-1:0] : addrPins,
                    data: bus, ale: ale, csN: csN, strobeA: sA,
                    strobeB: sB, busMode: busMode};

    // ------------------------------------------------------------
    // one byte access, answer taken one edge after the strobe
    // ------------------------------------------------------------
    task automatic access(input logic wr, input logic cs,
                          input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d,
                          output logic [DATA_W-1:0] q, output logic oe);
        @(posedge clk);
        #2;
        addrPins = a;
        hostOe   = wr;
        hostData = d;
        csN      = ~cs;
        sA       = busMode ? 1'b0 : wr;
        sB       = ~wr;
        @(posedge clk);
        #1;
        q  = bus;
        oe = dataOe;
        #1;
        csN      = 1'b1;
        sA       = 1'b1;
        sB       = 1'b1;
        hostOe   = 1'b0;
        addrPins = ~a;
        @(posedge clk);
    endtask

    task automatic latch(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        #2;
        muxed    = 1'b1;
        hostOe   = 1'b1;
        hostData = {1'b0, a};
        ale      = 1'b1;
        @(posedge clk);
        #2;
        ale      = 1'b0;
        // address held one more edge: the fall is seen there
        @(posedge clk);
        #2;
        hostData = ~hostData;
    endtask
endmodule // host_cpu_model

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
    import octet_port_pkg::*;
    logic              clk      = 1'b0;
    logic              rst_n    = 1'b0;
    logic [63:0]       irqEvent = '0;
    hostPins_t         hostPins;
    logic [DATA_W-1:0] dataOut;
    logic [DATA_W-1:0] q;
    logic              dataOe, irqOut, irqOe, oe;
    logic [DATA_W-1:0] shadow [128];
    int                error_cnt   = 0;
    int                checks_done = 0;

    octet_host_bus_port u_octet_host_bus_port (.clk(clk), .rst_n(rst_n),
        .hostPins(hostPins), .irqEvent(irqEvent), .dataOut(dataOut),
        .dataOe(dataOe), .irqOut(irqOut), .irqOe(irqOe));
    host_cpu_model u_host_cpu_model (.clk(clk), .dataOut(dataOut),
        .dataOe(dataOe), .pins(hostPins));

    initial begin
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------
    // expectations and shared tasks
    // ------------------------------------------------------------
    function automatic logic [6:0] plainAddr(input int unsigned r);
        if (r[0]) return 7'h42 + 7'(r % 62);
        return 7'(((r >> 1) % 4) * 16 + 4 + (r >> 3) % 12);
    endfunction

    function automatic logic [1:0] pinExp(input logic [1:0] c, input logic p);
        case (c)
            IRQ_PP_HIGH: return {1'b1, p};
            IRQ_PP_LOW:  return {1'b1, ~p};
            default:     return {p, 1'b0};
        endcase
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] want,
                         input string what);
        checks_done++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: %s %h not %h",
                     $time, what, got, want);
        end
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] want);
        u_host_cpu_model.access(1'b0, 1'b1, a, 8'h00, q, oe);
        check({7'h00, oe}, 8'h01, "read drive");
        check(q, want, "read data");
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host_cpu_model.access(1'b1, 1'b1, a, d, q, oe);
        check({7'h00, oe}, 8'h00, "write drive");
        shadow[a] = d;
    endtask

    task automatic pulse(input int b);
        @(posedge clk);
        #2 irqEvent[b] = 1'b1;
        @(posedge clk);
        #2 irqEvent[b] = 1'b0;
        @(posedge clk);
        #2;
    endtask

    task automatic pinChk(input int c, input logic p);
        check({6'h00, irqOe, irqOut}, {6'h00, pinExp(2'(c), p)}, "irq pin");
    endtask

    task automatic burst();
        logic [6:0] a [8];
        for (int i = 0; i < 8; i++) begin
            a[i] = plainAddr($urandom);
            wr(a[i], 8'($urandom));
        end
        for (int i = 0; i < 8; i++) begin
            rd(a[i], shadow[a[i]]);
        end
        u_host_cpu_model.access(1'b1, 1'b0, a[0], ~shadow[a[0]], q, oe);
        u_host_cpu_model.access(1'b0, 1'b0, a[0], 8'h00, q, oe);
        check({7'h00, oe}, 8'h00, "deselected drive");
        rd(a[0], shadow[a[0]]);
        $display("test burst style %0d done", u_host_cpu_model.busMode);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int         ch;
        int         k;
        logic [6:0] sa;
        logic [6:0] a1;
        void'($urandom(32'hD7E7));
        repeat (3) @(posedge clk);
        #2 rst_n = 1'b1;
        check({6'h00, irqOe, irqOut}, 8'h00, "reset pin");
        rd(7'h02, MASK_RESET);
        rd(ADDR_PIN_CFG, REG_RESET);
        rd(7'h00, REG_RESET);
        $display("test reset done");
        burst();
        u_host_cpu_model.busMode = 1'b1;
        burst();
        // every pin style, one unmasked and one masked source each
        for (int c = 0; c < 4; c++) begin
            ch = $urandom % 4;
            k  = $urandom % 16;
            sa = 7'(ch * 16 + k / 8);
            wr(ADDR_PIN_CFG, 8'(c));
            wr(sa + 7'h02, ~(8'h01 << (k % 8)));
            pulse(ch * 16 + k);
            pinChk(c, 1'b1);
            rd(ADDR_SUMMARY, 8'h01 << ch);
            rd(sa, 8'h01 << (k % 8));
            repeat (3) @(posedge clk);
            #2;
            pinChk(c, 1'b0);
            rd(sa, 8'h00);
            pulse(ch * 16 + (k ^ 1));
            pinChk(c, 1'b0);
            rd(sa, 8'h01 << ((k ^ 1) % 8));
            wr(sa + 7'h02, MASK_RESET);
        end
        $display("test interrupt done");
        // address pins follow the data lines once multiplexed
        a1 = plainAddr($urandom);
        u_host_cpu_model.latch(a1);
        wr(a1, 8'hA5);
        u_host_cpu_model.latch(a1 ^ 7'h01);
        wr(a1 ^ 7'h01, 8'h5A);
        u_host_cpu_model.latch(a1);
        rd(a1, 8'hA5);
        u_host_cpu_model.latch(a1 ^ 7'h01);
        rd(a1 ^ 7'h01, 8'h5A);
        $display("test multiplexed done");
        conclude();
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: run too long", $time);
        conclude();
    end
endmodule // tb
